//--- rxsq_regs.vh
// register offsets, field positions and reset values of the rx quality block
`ifndef RXSQ_REGS_VH
`define RXSQ_REGS_VH

`define RXSQ_ADDR_W            8
`define RXSQ_OFF_BLOCK_STATUS  8'h1_0
`define RXSQ_OFF_INBAND        8'h1_C
`define RXSQ_OFF_MULTIPATH     8'h2_1
`define RXSQ_OFF_IRQ_STATUS    8'h3_0
`define RXSQ_OFF_IRQ_MASK      8'h3_1
`define RXSQ_OFF_CONTROL       8'h3_2

`define RXSQ_BIT_BLOCK0_ERR    3
`define RXSQ_BIT_BLOCK1_ERR    2
`define RXSQ_BIT_BLOCK2_ERR    1
`define RXSQ_BIT_BLOCK3_ERR    0
`define RXSQ_BIT_UPD_TOGGLE    7

`define RXSQ_IRQ_GROUP         0
`define RXSQ_IRQ_ERROR         1
`define RXSQ_IRQ_LEVEL         2
`define RXSQ_IRQ_W             3

`define RXSQ_CTRL_RX_EN        0
`define RXSQ_CTRL_HOLD         1

`define RXSQ_RST_BYTE          8'h0_0
`define RXSQ_RST_CTRL          8'h0_1
`define RXSQ_INBAND_OFFSET_DB  8'h2_8
`define RXSQ_LEVEL_LOW_DEF     8'h3_C
`endif

//--- rxsq_sample_reg.v
// sampling register: captures a value when its load enable is high
`timescale 1ns/1ps
module rxsq_sample_reg
#(
    parameter WIDTH = 8
)
(
    input  wire             sys_clk_i,
    input  wire             reset_i,
    input  wire             load_i,
    input  wire [WIDTH-1:0] data_i,
    output reg  [WIDTH-1:0] data_o
);

    // synchronous clear, then load on enable
    always @(posedge sys_clk_i)
    begin
        if (reset_i)
            data_o <= {WIDTH{1'b0}};
        else if (load_i)
            data_o <= data_i;
    end

endmodule // rxsq_sample_reg

//--- rxsq_status.v
// receive signal quality status registers with group error flags and irq
//
// Overview of operation
// [R1] first block error of latest group sits in status bit 3
// [R2] second block error of latest group sits in status bit 2
// [R3] third block error of latest group sits in status bit 1
// [R4] fourth block error of latest group sits in status bit 0
// [R5] read-only 8-bit in-band signal strength at offset 1Ch, bits 7:0
// [R6] value includes gain correction; software subtracts 40 for dBuV
// [R7] read-only 7-bit multipath strength at 21h, bit 7 reserved zero
// [R8] group update flag inverts each time a new group completes; the code inverts it only while the rx enable control bit is set
// [R9] all four block error flags update together on group completion
`timescale 1ns/1ps
`include "rxsq_regs.vh"
module rxsq_status
#(
    parameter SAMPLE_DIV = 16
)
(
    input  wire       sys_clk_i,
    input  wire       reset_i,
    input  wire [7:0] reg_addr_i,
    input  wire [7:0] reg_wdata_i,
    input  wire       reg_write_i,
    input  wire       reg_read_i,
    output reg  [7:0] reg_rdata_o,
    input  wire       group_done_i,
    input  wire [3:0] block_error_i,
    input  wire [7:0] rssi_raw_i,
    input  wire [7:0] agc_correction_i,
    input  wire [6:0] multipath_raw_i,
    output wire       rx_enable_o,
    output wire       irq_o
);

    // divider state and enable
    reg  [15:0] div_count;
    wire        sample_tick;

    // register contents
    reg  [3:0]  block_errors;
    reg         group_update_toggle;
    reg  [7:0]  control;
    reg  [`RXSQ_IRQ_W-1:0] irq_status;
    reg  [`RXSQ_IRQ_W-1:0] irq_mask;
    reg  [7:0]  level_low;
    wire [7:0]  inband_signal_strength;
    wire [7:0]  multipath_signal_strength;
    wire [7:0]  next_inband;
    wire [8:0]  inband_sum;
    wire        group_take;
    wire        sample_load;
    wire        level_event;
    wire [`RXSQ_IRQ_W-1:0] irq_events;
    wire [`RXSQ_IRQ_W-1:0] irq_clear;
    reg  [7:0]  next_rdata;

    // slow sampling tick keeps the readings steady between host reads
    always @(posedge sys_clk_i)
    begin
        if (reset_i)
            div_count <= 16'h0000;
        else if (sample_tick)
            div_count <= 16'h0000;
        else
            div_count <= div_count + 16'h0001;
    end
    assign sample_tick = (div_count == SAMPLE_DIV[15:0] - 16'h0001);

    // gain corrected strength, saturates rather than wrapping
    assign inband_sum  = {1'b0, rssi_raw_i} + {1'b0, agc_correction_i};
    assign next_inband = inband_sum[8] ? 8'hFF : inband_sum[7:0]; // see [R6]

    // hold bit freezes the readings while software compares them
    assign sample_load = sample_tick & ~control[`RXSQ_CTRL_HOLD];
    assign rx_enable_o = control[`RXSQ_CTRL_RX_EN];

    // in-band strength sampler
    rxsq_sample_reg #(.WIDTH(8)) u_inband
    (
        .sys_clk_i (sys_clk_i),
        .reset_i   (reset_i),
        .load_i    (sample_load),
        .data_i    (next_inband),
        .data_o    (inband_signal_strength) // see [R5]
    );

    // multipath sampler, top bit stays zero as reserved
    rxsq_sample_reg #(.WIDTH(8)) u_multipath
    (
        .sys_clk_i (sys_clk_i),
        .reset_i   (reset_i),
        .load_i    (sample_load),
        .data_i    ({1'b0, multipath_raw_i}),
        .data_o    (multipath_signal_strength) // see [R7]
    );

    // groups only counted while receive is enabled
    assign group_take = group_done_i & control[`RXSQ_CTRL_RX_EN];

    // all four flags load in one edge so a read never mixes two groups
    always @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            block_errors        <= 4'h0;
            group_update_toggle <= 1'b0;
        end
        else if (group_take)
        begin
            block_errors        <= block_error_i;      // see [R9]
            group_update_toggle <= ~group_update_toggle; // see [R8]
        end
    end

    // events: new group, any block error, weak signal sample
    assign level_event = sample_load & (next_inband < level_low);
    assign irq_events  = {level_event, group_take & (|block_error_i),
                          group_take};
    assign irq_clear   = (reg_write_i &&
                          reg_addr_i == `RXSQ_OFF_IRQ_STATUS) ?
                         reg_wdata_i[`RXSQ_IRQ_W-1:0] : {`RXSQ_IRQ_W{1'b0}};

    // sticky status, a new event wins over a simultaneous clear
    always @(posedge sys_clk_i)
    begin
        if (reset_i)
            irq_status <= {`RXSQ_IRQ_W{1'b0}};
        else
            irq_status <= (irq_status & ~irq_clear) | irq_events;
    end

    // software writable registers
    always @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            irq_mask  <= {`RXSQ_IRQ_W{1'b0}};
            control   <= `RXSQ_RST_CTRL;
            level_low <= `RXSQ_LEVEL_LOW_DEF;
        end
        else if (reg_write_i)
        begin
            case (reg_addr_i)
                `RXSQ_OFF_IRQ_MASK:
                    irq_mask <= reg_wdata_i[`RXSQ_IRQ_W-1:0];
                `RXSQ_OFF_CONTROL:
                    control <= {6'b000000, reg_wdata_i[1:0]};
                `RXSQ_OFF_CONTROL + 8'h01:
                    level_low <= reg_wdata_i;
                default:
                    control <= control;
            endcase
        end
    end

    assign irq_o = |(irq_status & irq_mask);

    // read mux; unmapped addresses return zero
    always @*
    begin
        next_rdata = 8'h00;
        case (reg_addr_i)
            `RXSQ_OFF_BLOCK_STATUS:
            begin
                next_rdata[`RXSQ_BIT_UPD_TOGGLE] = group_update_toggle;
                next_rdata[`RXSQ_BIT_BLOCK0_ERR] = block_errors[0]; // see [R1]
                next_rdata[`RXSQ_BIT_BLOCK1_ERR] = block_errors[1]; // see [R2]
                next_rdata[`RXSQ_BIT_BLOCK2_ERR] = block_errors[2]; // see [R3]
                next_rdata[`RXSQ_BIT_BLOCK3_ERR] = block_errors[3]; // see [R4]
            end
            `RXSQ_OFF_INBAND:
                next_rdata = inband_signal_strength; // see [R5]
            `RXSQ_OFF_MULTIPATH:
                next_rdata = multipath_signal_strength; // see [R7]
            `RXSQ_OFF_IRQ_STATUS:
                next_rdata[`RXSQ_IRQ_W-1:0] = irq_status;
            `RXSQ_OFF_IRQ_MASK:
                next_rdata[`RXSQ_IRQ_W-1:0] = irq_mask;
            `RXSQ_OFF_CONTROL:
                next_rdata = control;
            `RXSQ_OFF_CONTROL + 8'h01:
                next_rdata = level_low;
            default:
                next_rdata = 8'h00;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always @(posedge sys_clk_i)
    begin
        if (reset_i)
            reg_rdata_o <= 8'h00;
        else if (reg_read_i)
            reg_rdata_o <= next_rdata;
        else
            reg_rdata_o <= 8'h00;
    end

endmodule // rxsq_status

//--- rxsq_status_props.sv
// concurrent checks on the rx quality status ports
`timescale 1ns/1ps
module rxsq_status_props (
    input wire       sys_clk_i,
    input wire       reset_i,
    input wire [7:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire       reg_write_i,
    input wire       reg_read_i,
    input wire [7:0] reg_rdata_o,
    input wire       group_done_i,
    input wire [3:0] block_error_i,
    input wire       rx_enable_o,
    input wire       irq_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    // a taken group, then a status read in the very next cycle
    sequence grp_rd;
        (group_done_i && rx_enable_o) ##1
        (reg_read_i && reg_addr_i == 8'h10);
    endsequence
    AST_RD_IDLE: assert property (!$past(reg_read_i) |->
        reg_rdata_o == 8'h00) else $error("read data not idle");
    AST_MP_RSVD: assert property ((reg_read_i &&
        reg_addr_i == 8'h21) |=> !reg_rdata_o[7])
        else $error("multipath reserved bit set");
    AST_BLK0: assert property (grp_rd |=>
        reg_rdata_o[3] == $past(block_error_i[0], 2))
        else $error("block0 flag wrong");
    AST_BLK1: assert property (grp_rd |=>
        reg_rdata_o[2] == $past(block_error_i[1], 2))
        else $error("block1 flag wrong");
    AST_BLK2: assert property (grp_rd |=>
        reg_rdata_o[1] == $past(block_error_i[2], 2))
        else $error("block2 flag wrong");
    AST_BLK3: assert property (grp_rd |=>
        reg_rdata_o[0] == $past(block_error_i[3], 2))
        else $error("block3 flag wrong");
    AST_TOGGLE: assert property ((reg_read_i &&
        reg_addr_i == 8'h10 && group_done_i && rx_enable_o) ##1
        (reg_read_i && reg_addr_i == 8'h10) |=>
        reg_rdata_o[7] != $past(reg_rdata_o[7]))
        else $error("update toggle did not invert");
    AST_IRQ_MASK: assert property ((reg_write_i &&
        reg_addr_i == 8'h31 && reg_wdata_i == 8'h00) |=> !irq_o)
        else $error("irq high with all masked");
endmodule // rxsq_status_props
bind rxsq_status rxsq_status_props u_props (.sys_clk_i(sys_clk_i),
    .reset_i(reset_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
    .reg_rdata_o(reg_rdata_o), .group_done_i(group_done_i),
    .block_error_i(block_error_i), .rx_enable_o(rx_enable_o),
    .irq_o(irq_o));

//--- rxsq_status_tb.sv
// self-checking bench for the rx quality status block
`timescale 1ns/1ps
module rxsq_status_tb;
    localparam DIV = 4;
    logic       clk = 0, rst = 1, wr = 0, rd = 0, gd = 0, tog = 0;
    logic [7:0] addr = 0, wdat = 0, raw = 0, agc = 0, rdata, sat;
    logic [6:0] mp = 0;
    logic [3:0] errs = 0, lst = 0;
    logic       rx_en, irq, rd_d = 0;
    logic [7:0] exp_q[$], msk_q[$];
    int         num_errors = 0, comparisons = 0, cyc = 0;
    rxsq_status #(.SAMPLE_DIV(DIV)) DUT (.sys_clk_i(clk), .reset_i(rst),
        .reg_addr_i(addr), .reg_wdata_i(wdat), .reg_write_i(wr),
        .reg_read_i(rd), .reg_rdata_o(rdata), .group_done_i(gd),
        .block_error_i(errs), .rssi_raw_i(raw), .agc_correction_i(agc),
        .multipath_raw_i(mp), .rx_enable_o(rx_en), .irq_o(irq));
    initial forever #5 clk = ~clk;
    task chk(input string nm, input logic [7:0] seen, exp);
        comparisons++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task finish_test;
        if (num_errors == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task wrr(input logic [7:0] a, d);
        @(posedge clk);
        {addr, wdat, wr} <= {a, d, 1'b1};
        @(posedge clk);
        wr <= 0;
    endtask
    task rdr(input logic [7:0] a, e, m);
        @(posedge clk);
        {addr, rd} <= {a, 1'b1};
        exp_q.push_back(e & m);
        msk_q.push_back(m);
        @(posedge clk);
        rd <= 0;
    endtask
    // group pulse read in its own cycle and in the next one
    task grpr(input logic [3:0] e, input logic en);
        @(posedge clk);
        {errs, gd, addr, rd} <= {e, 1'b1, 8'h10, 1'b1};
        exp_q.push_back(0);
        msk_q.push_back(0);
        lst = en ? {e[0], e[1], e[2], e[3]} : lst;
        tog ^= en;
        exp_q.push_back({tog, 3'b000, lst});
        msk_q.push_back(8'hff);
        @(posedge clk);
        gd <= 0;
        @(posedge clk);
        rd <= 0;
    endtask
    // oldest note meets each read answer; the cycle cap cuts a hang
    always @(posedge clk)
    begin
        rd_d <= rd;
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            num_errors++;
            finish_test();
        end
        if (rd_d)
            chk("rdata", rdata & msk_q.pop_front(), exp_q.pop_front());
    end
    initial
    begin
        void'($urandom(32'hdf85_2787));
        repeat (8) @(posedge clk);
        rst <= 0;
        rdr(8'h32, 8'h01, 8'hff);
        rdr(8'h33, 8'h3c, 8'hff);
        rdr(8'h10, 8'h00, 8'hff);
        rdr(8'h55, 8'h00, 8'hff);
        wrr(8'h31, 8'h00);
        repeat (6)
        begin
            {raw, agc, mp} <= {8'($urandom), 8'($urandom), 7'($urandom)};
            repeat (2 * DIV) @(posedge clk);
            sat = ({1'b0, raw} + agc > 255) ? 8'hff : raw + agc;
            rdr(8'h1c, sat, 8'hff);
            rdr(8'h21, {1'b0, mp}, 8'hff);
        end
        wrr(8'h32, 8'h03);
        raw <= ~raw;
        repeat (2 * DIV) @(posedge clk);
        wrr(8'h1c, 8'h5a);
        rdr(8'h1c, sat, 8'hff);
        wrr(8'h32, 8'h01);
        for (int i = 0; i < 16; i++)
        begin
            grpr(4'(i), 1'b1);
            rdr(8'h30, {6'b0, i != 0, 1'b1}, 8'h03);
            wrr(8'h30, 8'h07);
        end
        wrr(8'h31, 8'h01);
        grpr(4'h0, 1'b1);
        #1 chk("irq", {7'b0, irq}, 8'h01);
        wrr(8'h30, 8'h07);
        #1 chk("irq", {7'b0, irq}, 8'h00);
        wrr(8'h32, 8'h00);
        grpr(4'hf, 1'b0);
        repeat (4) @(posedge clk);
        finish_test();
    end
endmodule // rxsq_status_tb
